// file: design/gpr_port_regs.v
// port register set with general ports a, b, d and the high-voltage open-collector port
// Behaviour
// - pull-up disable bit kills every pull-up
// - bit set/clear touches only one latch
// - high-voltage port has one data address
// - high-voltage data register reads back the low four written bits, upper bits zero
// - high-voltage pins sink or float only
// - one write, one read strobe for the high-voltage port
// - latch one pulls low, zero floats
// - reset floats high-voltage pins without clock
`timescale 1ns/1ps
`default_nettype none
`include "gpr_regs.vh"

module gpr_port_regs (
  // clock and reset
  input  wire                    sys_clk_i,
  input  wire                    rst_n_i,
  // register port
  input  wire [`GPR_ADDR_W-1:0]  io_addr_i,
  input  wire                    io_wr_i,
  input  wire                    io_rd_i,
  input  wire [7:0]              io_wdata_i,
  output reg  [7:0]              io_rdata_o,
  // single-bit instruction port
  input  wire                    set_single_bit_instr_i,
  input  wire                    clear_single_bit_instr_i,
  input  wire [2:0]              bit_sel_i,
  // port a pins
  input  wire [7:0]              bank_a_pin_i,
  output wire [7:0]              bank_a_pin_o,
  output wire [7:0]              bank_a_pin_oe_o,
  output wire [7:0]              bank_a_pullup_o,
  // port b pins
  input  wire [7:0]              bank_b_pin_i,
  output wire [7:0]              bank_b_pin_o,
  output wire [7:0]              bank_b_pin_oe_o,
  output wire [7:0]              bank_b_pullup_o,
  // port d pins
  input  wire [`GPR_D_WIDTH-1:0] bank_d_pin_i,
  output wire [`GPR_D_WIDTH-1:0] bank_d_pin_o,
  output wire [`GPR_D_WIDTH-1:0] bank_d_pin_oe_o,
  output wire [`GPR_D_WIDTH-1:0] bank_d_pullup_o,
  // high-voltage open-collector pins
  output wire [`GPR_HV_WIDTH-1:0] hv_pin_o,
  output wire [`GPR_HV_WIDTH-1:0] hv_pin_oe_o,
  // control outputs
  output wire                    debug_iface_off_o,
  output wire                    vector_table_select_o,
  output wire                    vector_change_enable_o
);

  reg  [7:0]               a_dir_reg;
  reg  [7:0]               a_out_reg;
  reg  [7:0]               b_dir_reg;
  reg  [7:0]               b_out_reg;
  reg  [`GPR_D_WIDTH-1:0]  d_dir_reg;
  reg  [`GPR_D_WIDTH-1:0]  d_out_reg;
  reg  [`GPR_HV_WIDTH-1:0] hv_out_reg;
  reg  [7:0]               ctrl_reg;
  reg  [7:0]               a_sync1_reg;
  reg  [7:0]               a_sync2_reg;
  reg  [7:0]               b_sync1_reg;
  reg  [7:0]               b_sync2_reg;
  reg  [`GPR_D_WIDTH-1:0]  d_sync1_reg;
  reg  [`GPR_D_WIDTH-1:0]  d_sync2_reg;
  reg  [7:0]               rdata_next;

  wire                     bit_op;
  wire [7:0]               bit_mask;
  wire                     pu_off;
  wire                     hv_wr_strobe;
  wire                     hv_rd_strobe;
  wire                     reg_we;
  wire                     a_dir_we;
  wire                     a_out_we;
  wire                     b_dir_we;
  wire                     b_out_we;
  wire                     d_dir_we;
  wire                     d_out_we;
  wire                     ctrl_we;
  wire [7:0]               d_dir_upd;
  wire [7:0]               d_out_upd;
  wire [7:0]               hv_upd;

  // single-bit instruction decode
  assign bit_op   = set_single_bit_instr_i | clear_single_bit_instr_i;
  assign bit_mask = 8'h01 << bit_sel_i;
  assign pu_off   = ctrl_reg[`GPR_CTRL_PU_OFF];

  // one shared strobe pair for the whole high-voltage port
  assign hv_wr_strobe = (io_wr_i | bit_op) && (io_addr_i == `GPR_HV_OUT_OFS);
  assign hv_rd_strobe = io_rd_i && (io_addr_i == `GPR_HV_OUT_OFS);

  // merge a write or a single-bit op into a register value
  function [7:0] upd;
    input [7:0] cur;
    begin
      if (set_single_bit_instr_i) begin
        upd = cur | bit_mask;
      end else if (clear_single_bit_instr_i) begin
        upd = cur & ~bit_mask;
      end else begin
        upd = io_wdata_i;
      end
    end
  endfunction

  // per-register write enables, a write or a single-bit op
  assign reg_we   = io_wr_i | bit_op;
  assign a_dir_we = reg_we && (io_addr_i == `GPR_A_DIR_OFS);
  assign a_out_we = reg_we && (io_addr_i == `GPR_A_OUT_OFS);
  assign b_dir_we = reg_we && (io_addr_i == `GPR_B_DIR_OFS);
  assign b_out_we = reg_we && (io_addr_i == `GPR_B_OUT_OFS);
  assign d_dir_we = reg_we && (io_addr_i == `GPR_D_DIR_OFS);
  assign d_out_we = reg_we && (io_addr_i == `GPR_D_OUT_OFS);
  assign ctrl_we  = reg_we && (io_addr_i == `GPR_CTRL_OFS);

  // narrow ports merge through the byte-wide update
  assign d_dir_upd = upd({6'h00, d_dir_reg});
  assign d_out_upd = upd({6'h00, d_out_reg});
  assign hv_upd    = upd({4'h0, hv_out_reg});

  // pin synchronisers
  always @(posedge sys_clk_i) begin
    a_sync1_reg <= bank_a_pin_i;
    a_sync2_reg <= a_sync1_reg;
    b_sync1_reg <= bank_b_pin_i;
    b_sync2_reg <= b_sync1_reg;
    d_sync1_reg <= bank_d_pin_i;
    d_sync2_reg <= d_sync1_reg;
  end

  // register writes
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      a_dir_reg <= `GPR_RST_8;
      a_out_reg <= `GPR_RST_8;
      b_dir_reg <= `GPR_RST_8;
      b_out_reg <= `GPR_RST_8;
      d_dir_reg <= `GPR_RST_D;
      d_out_reg <= `GPR_RST_D;
      ctrl_reg  <= `GPR_RST_8;
    end else begin
      if (a_dir_we) begin
        a_dir_reg <= upd(a_dir_reg);
      end
      if (a_out_we) begin
        a_out_reg <= upd(a_out_reg);
      end
      if (b_dir_we) begin
        b_dir_reg <= upd(b_dir_reg);
      end
      if (b_out_we) begin
        b_out_reg <= upd(b_out_reg);
      end
      if (d_dir_we) begin
        d_dir_reg <= d_dir_upd[`GPR_D_WIDTH-1:0];
      end
      if (d_out_we) begin
        d_out_reg <= d_out_upd[`GPR_D_WIDTH-1:0];
      end
      if (ctrl_we) begin
        ctrl_reg <= upd(ctrl_reg) & `GPR_CTRL_WMASK;
      end
    end
  end

  // high-voltage latch, cleared asynchronously so pins float with no clock
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hv_out_reg <= `GPR_RST_HV;
    end else if (hv_wr_strobe) begin
      hv_out_reg <= hv_upd[`GPR_HV_WIDTH-1:0];
    end
  end

  // read mux
  always @* begin
    rdata_next = 8'h00;
    case (io_addr_i)
      `GPR_A_PIN_OFS: rdata_next = a_sync2_reg;
      `GPR_A_DIR_OFS: rdata_next = a_dir_reg;
      `GPR_A_OUT_OFS: rdata_next = a_out_reg;
      `GPR_B_PIN_OFS: rdata_next = b_sync2_reg;
      `GPR_B_DIR_OFS: rdata_next = b_dir_reg;
      `GPR_B_OUT_OFS: rdata_next = b_out_reg;
      `GPR_D_PIN_OFS: rdata_next = {6'h00, d_sync2_reg};
      `GPR_D_DIR_OFS: rdata_next = {6'h00, d_dir_reg};
      `GPR_D_OUT_OFS: rdata_next = {6'h00, d_out_reg};
      `GPR_HV_OUT_OFS: rdata_next = hv_rd_strobe ? {4'h0, hv_out_reg} : 8'h00;
      `GPR_CTRL_OFS:  rdata_next = ctrl_reg;
      default:        rdata_next = 8'h00;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      io_rdata_o <= `GPR_RST_8;
    end else if (io_rd_i) begin
      io_rdata_o <= rdata_next;
    end
  end

  // general port pin drive
  assign bank_a_pin_o    = a_out_reg;
  assign bank_a_pin_oe_o = a_dir_reg;
  assign bank_a_pullup_o = ~a_dir_reg & a_out_reg & {8{~pu_off}};
  assign bank_b_pin_o    = b_out_reg;
  assign bank_b_pin_oe_o = b_dir_reg;
  assign bank_b_pullup_o = ~b_dir_reg & b_out_reg & {8{~pu_off}};
  assign bank_d_pin_o    = d_out_reg;
  assign bank_d_pin_oe_o = d_dir_reg;
  assign bank_d_pullup_o = ~d_dir_reg & d_out_reg & {`GPR_D_WIDTH{~pu_off}};

  // open collector: drive zero when latch is one, else float
  assign hv_pin_o    = {`GPR_HV_WIDTH{1'b0}};
  assign hv_pin_oe_o = hv_out_reg & {`GPR_HV_WIDTH{rst_n_i}};

  // control bits
  assign debug_iface_off_o      = ctrl_reg[`GPR_CTRL_DBG_OFF];
  assign vector_table_select_o  = ctrl_reg[`GPR_CTRL_VEC_SEL];
  assign vector_change_enable_o = ctrl_reg[`GPR_CTRL_VEC_CHG];

endmodule

`default_nettype wire

// file: design/gpr_regs.vh
// register offsets, field positions and reset values of the port register block
`ifndef GPR_REGS_VH
`define GPR_REGS_VH

`define GPR_ADDR_W          6
`define GPR_A_PIN_OFS       6'h00
`define GPR_A_DIR_OFS       6'h01
`define GPR_A_OUT_OFS       6'h02
`define GPR_B_PIN_OFS       6'h03
`define GPR_B_DIR_OFS       6'h04
`define GPR_B_OUT_OFS       6'h05
`define GPR_D_PIN_OFS       6'h09
`define GPR_D_DIR_OFS       6'h0a
`define GPR_D_OUT_OFS       6'h0b
`define GPR_HV_OUT_OFS      6'h08
`define GPR_CTRL_OFS        6'h35

`define GPR_CTRL_DBG_OFF    7
`define GPR_CTRL_PU_OFF     4
`define GPR_CTRL_VEC_SEL    1
`define GPR_CTRL_VEC_CHG    0
`define GPR_CTRL_WMASK      8'h93

`define GPR_D_WIDTH         2
`define GPR_HV_WIDTH        4
`define GPR_RST_8           8'h00
`define GPR_RST_D           2'h0
`define GPR_RST_HV          4'h0

`endif

// file: tb/gpr_pin_model.sv
// external load of port a pins
`timescale 1ns/1ps
`default_nettype none
module gpr_pin_model (
  input  wire logic [7:0] drv_i, oe_i, pu_i, ext_i, en_i,
  output wire logic [7:0] lvl_o
);
  // driven, else external, else pull-up, else floating (inverted)
  assign lvl_o = oe_i & drv_i | ~oe_i & (en_i & ext_i | ~en_i & (pu_i | ~ext_i));
endmodule
`default_nettype wire

// file: tb/gpr_port_regs_properties.sv
// assertions for the port register block
`timescale 1ns/1ps
`default_nettype none
module gpr_props (
  input wire logic       sys_clk_i, rst_n_i, io_wr_i, io_rd_i,
  input wire logic [5:0] io_addr_i,
  input wire logic [7:0] io_wdata_i, io_rdata_o, bank_a_pin_o, bank_a_pin_oe_o, bank_a_pullup_o,
  input wire logic [3:0] hv_pin_o, hv_pin_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_hvw; io_wr_i && io_addr_i == 6'h08; endsequence
  property p_pu; (bank_a_pullup_o & (bank_a_pin_oe_o | ~bank_a_pin_o)) == 8'h00; endproperty
  a_pu: assert property (p_pu) else $error("stray pull-up");
  property p_hv0; hv_pin_o == 4'h0; endproperty
  a_hv0: assert property (p_hv0) else $error("hv high");
  property p_rst; disable iff (1'b0) !rst_n_i |-> hv_pin_oe_o == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("hv sinks in reset");
  property p_hvw; s_hvw |=> {4'h0, hv_pin_oe_o} == ($past(io_wdata_i) & 8'h0f); endproperty
  a_hvw: assert property (p_hvw) else $error("hv latch");
  property p_rb;
    s_hvw ##1 (io_rd_i && io_addr_i == 6'h08) |=> io_rdata_o == ($past(io_wdata_i, 2) & 8'h0f);
  endproperty
  a_rb: assert property (p_rb) else $error("hv readback");
  property p_st; !io_rd_i |=> $stable(io_rdata_o); endproperty
  a_st: assert property (p_st) else $error("read data moved");
  property p_un; io_rd_i && io_addr_i == 6'h3f |=> io_rdata_o == 8'h00; endproperty
  a_un: assert property (p_un) else $error("unmapped read");
  property p_a; io_wr_i && io_addr_i == 6'h02 |=> bank_a_pin_o == $past(io_wdata_i); endproperty
  a_a: assert property (p_a) else $error("latch a");
endmodule
bind gpr_port_regs gpr_props i_gpr_props (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .io_wr_i(io_wr_i),
  .io_rd_i(io_rd_i),
  .io_addr_i(io_addr_i),
  .io_wdata_i(io_wdata_i),
  .io_rdata_o(io_rdata_o),
  .bank_a_pin_o(bank_a_pin_o),
  .bank_a_pin_oe_o(bank_a_pin_oe_o),
  .bank_a_pullup_o(bank_a_pullup_o),
  .hv_pin_o(hv_pin_o),
  .hv_pin_oe_o(hv_pin_oe_o)
);
`default_nettype wire

// file: tb/gpr_port_regs_tb.sv
// self-checking bench for the port register block
`timescale 1ns/1ps
`default_nettype none
module gpr_port_regs_tb;
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, st = 1'b0, cl = 1'b0;
  logic [2:0] bs = 3'h0;
  logic [5:0] ad = 6'h00;
  logic [7:0] wd = 8'h00, rdat, a_in, a_o, a_oe, a_pu, ext = 8'h00, en = 8'h00;
  logic [7:0] b_o, b_oe, b_pu, b_in = 8'h00;
  logic [1:0] d_o, d_oe, d_pu, d_in = 2'h3;
  logic       dbg, vsel, vchg;
  logic [3:0] hv_o, hv_oe;
  int         n_fail = 0, checks = 0;
  gpr_port_regs i_gpr_port_regs (.sys_clk_i(clk), .rst_n_i(rst_n), .io_addr_i(ad), .io_wr_i(wr), .io_rd_i(rd),
    .io_wdata_i(wd), .io_rdata_o(rdat), .set_single_bit_instr_i(st), .clear_single_bit_instr_i(cl), .bit_sel_i(bs),
    .bank_a_pin_i(a_in), .bank_a_pin_o(a_o), .bank_a_pin_oe_o(a_oe), .bank_a_pullup_o(a_pu), .bank_b_pin_i(b_in),
    .bank_b_pin_o(b_o), .bank_b_pin_oe_o(b_oe), .bank_b_pullup_o(b_pu), .bank_d_pin_i(d_in), .bank_d_pin_o(d_o),
    .bank_d_pin_oe_o(d_oe), .bank_d_pullup_o(d_pu), .hv_pin_o(hv_o), .hv_pin_oe_o(hv_oe), .debug_iface_off_o(dbg),
    .vector_table_select_o(vsel), .vector_change_enable_o(vchg));
  gpr_pin_model i_gpr_pin_model (.drv_i(a_o), .oe_i(a_oe), .pu_i(a_pu), .ext_i(ext), .en_i(en), .lvl_o(a_in));
  initial forever #5 clk = ~clk;
  task automatic chk(string n, logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wrt(logic [5:0] a, logic [7:0] d);
    @(negedge clk) ad = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk) wr = 1'b0;
  endtask
  task automatic rdc(string n, logic [5:0] a, logic [7:0] e);
    ad = a;
    rd = 1'b1;
    @(negedge clk) rd = 1'b0;
    @(negedge clk) chk(n, rdat, e);
  endtask
  task automatic bop(logic [5:0] a, logic s, logic [2:0] b);
    @(negedge clk) ad = a;
    bs = b;
    st = s;
    cl = !s;
    @(negedge clk) {st, cl} = 2'b00;
  endtask
  task automatic t_hv;
    wrt(6'h08, 8'ha5);
    rdc("hv", 6'h08, 8'h05);
    chk("hv_oe", {4'h0, hv_oe}, 8'h05);
    bop(6'h08, 1'b1, 3'h1);
    bop(6'h08, 1'b0, 3'h0);
    rdc("hv", 6'h08, 8'h06);
    chk("hv_o", {4'h0, hv_o}, 8'h00);
    wrt(6'h3f, 8'hff);
    rdc("unmap", 6'h3f, 8'h00);
  endtask
  task automatic t_pu;
    wrt(6'h01, 8'h0f);
    wrt(6'h02, 8'hff);
    chk("pu", a_pu, 8'hf0);
    wrt(6'h35, 8'hff);
    chk("pu", a_pu, 8'h00);
    chk("ctl", {5'h00, dbg, vsel, vchg}, 8'h07);
    rdc("ctrl", 6'h35, 8'h93);
  endtask
  task automatic t_pin;
    en = 8'hf0;
    ext = 8'ha0;
    repeat (3) @(negedge clk);
    rdc("lvl_a", 6'h00, 8'haf);
    rdc("lvl_d", 6'h09, 8'h03);
    bop(6'h02, 1'b0, 3'h0);
    rdc("out_a", 6'h02, 8'hfe);
  endtask
  task automatic t_rst;
    wrt(6'h08, 8'h0f);
    rst_n = 1'b0;
    #1 chk("hv_rst", {4'h0, hv_oe}, 8'h00);
    @(negedge clk) rst_n = 1'b1;
    rdc("hv", 6'h08, 8'h00);
    rdc("ctrl", 6'h35, 8'h00);
    chk("ctl", {5'h00, dbg, vsel, vchg}, 8'h00);
  endtask
  task automatic t_bd;
    wrt(6'h04, 8'h5a);
    wrt(6'h05, 8'hf0);
    chk("pu_b", b_pu, 8'ha0);
    bop(6'h05, 1'b1, 3'h0);
    bop(6'h04, 1'b0, 3'h1);
    chk("out_b", b_o, 8'hf1);
    chk("dir_b", b_oe, 8'h58);
    wrt(6'h0a, 8'hfe);
    wrt(6'h0b, 8'hff);
    chk("pu_d", {6'h00, d_pu}, 8'h01);
    bop(6'h0b, 1'b0, 3'h0);
    chk("out_d", {6'h00, d_o}, 8'h02);
    chk("dir_d", {6'h00, d_oe}, 8'h02);
    rdc("out_d", 6'h0b, 8'h02);
    b_in = 8'h3c;
    d_in = 2'h1;
    wrt(6'h03, 8'hff);
    repeat (2) @(negedge clk);
    rdc("lvl_b", 6'h03, 8'h3c);
    rdc("lvl_d", 6'h09, 8'h01);
  endtask
  task automatic conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    t_hv;
    t_pu;
    t_pin;
    t_rst;
    t_bd;
    conclude;
  end
  initial begin
    #3000;
    n_fail++;
    conclude;
  end
endmodule
`default_nettype wire
